// [cruise_map.svh]
// speed hold constants: timing, limits, register map
// assumes 200 MHz clock; one sensor pulse per gate is 1 km/h
`ifndef CRUISE_MAP_SVH
`define CRUISE_MAP_SVH
`define CLK_HZ 200000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define NOPULSE_MS 500
`define NOPULSE_CYC (`CYC_PER_MS * `NOPULSE_MS)
`define ALARM_MS 200
`define ALARM_CYC (`CYC_PER_MS * `ALARM_MS)
`define OD_MS 2000
`define OD_CYC (`CYC_PER_MS * `OD_MS)
`define DEBOUNCE_MS 10
`define DEBOUNCE_CYC (`CYC_PER_MS * `DEBOUNCE_MS)
`define GATE_MS 100
`define GATE_CYC (`CYC_PER_MS * `GATE_MS)
`define DIAG_UNIT_MS 250
`define DIAG_UNIT_CYC (`CYC_PER_MS * `DIAG_UNIT_MS)
`define TRIM_MS 50
`define TRIM_CYC (`CYC_PER_MS * `TRIM_MS)
`define PW_SHIFT 10
`define SPEED_LOW 8'h28
`define SPEED_HIGH 8'h91
`define SPEED_DROP 8'h14
`define SPEED_DIAG 8'h14
`define REG_STATUS 4'h0
`define REG_DIAG 4'h4
`define REG_GAIN 4'h8
`define TRIM_GAIN_RST 8'h04
`define INIT_GAIN_RST 8'h10
`define CAUSE_LOAD 0
`define CAUSE_SENSOR 1
`define CAUSE_LOW 2
`define CAUSE_DROP 3
`define CAUSE_SWITCH 4
`define CAUSE_CANCEL 5
`define DIAG_PAT_W 20
`endif

// [cruise_pkg.sv]
// types of the speed hold controller
// constants live in cruise_map.svh
package cruise_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_DECELERATE = 3'b011,
        ST_ACCELERATE = 3'b100
    } mode_e;
endpackage

// [cruise_speed_controller.sv]
// speed hold controller with cause memory, blink codes, Avalon-MM slave
// assumes async switch and sensor pins; throttle_i
// comes from clk_i logic
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "cruise_map.svh"

// Operation
// - no control unless main switch on
// - set falling edge above 40 km/h stores target, holds
// - one initial pull pulse sized to speed
// - trim pulses sized by deviation and throttle
// - set held releases; its release stores target
// - resume rise at 40 km/h or more restores target
// - resume held pulls; its release stores target
// - stop lamp or inhibitor drops clutch
// - second brake contact also cancels
// - cancel at or below 40 km/h
// - target clamped to 145 km/h
// - cancel 20 km/h or more below target
// - cancel after 0.5 s without pulse
// - cancel on open load-side line
// - cancel on cancel plus command
// - set and resume together decelerate
// - any set or resume press with main on sounds alarm 0.2 s
// - pedal indication off while holding
// - timed overdrive cancel on sag, resume, pull
// - blink codes only with main on
// - display after cancel below 20 km/h
// - each cancel records its cause
// - codes shown smallest first
// - main off erases codes
module cruise_speed_controller
    import cruise_pkg::*;
#(
    parameter int unsigned NOPULSE_CYC = `NOPULSE_CYC,
    parameter int unsigned ALARM_CYC = `ALARM_CYC,
    parameter int unsigned OD_CYC = `OD_CYC,
    parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC,
    parameter int unsigned GATE_CYC = `GATE_CYC,
    parameter int unsigned DIAG_UNIT_CYC = `DIAG_UNIT_CYC,
    parameter int unsigned TRIM_CYC = `TRIM_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic main_sw_i,
    input wire logic set_sw_i,
    input wire logic resume_sw_i,
    input wire logic stop_sw_i,
    input wire logic brake_nc_i,
    input wire logic load_ok_i,
    input wire logic inhibit_i,
    input wire logic pedal_i,
    input wire logic speed_pulse_i,
    input wire logic [7:0] throttle_i,
    input wire logic [3:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    output logic motor_pull_o,
    output logic motor_release_o,
    output logic clutch_o,
    output logic alarm_o,
    output logic od_cancel_o,
    output logic pedal_ind_o,
    output logic diag_o
);

    if (NOPULSE_CYC < 1 || ALARM_CYC < 1 || OD_CYC < 1 ||
        DEBOUNCE_CYC < 1 || GATE_CYC < 1 || DIAG_UNIT_CYC < 1 ||
        TRIM_CYC < 1) begin : g_bad_param
        $error("timing parameters must be at least one cycle");
    end

    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic [7:0] sw;
        logic [7:0] sw_prev;
        logic [7:0][31:0] db_cnt;
        logic pulse_prev;
        logic [31:0] gate_cnt;
        logic [31:0] idle_cnt;
        logic [7:0] pcount;
        logic [7:0] speed;
        logic [7:0] target;
        logic tvalid;
        mode_e mode;
        logic [31:0] pulse_cnt;
        logic dir_pull;
        logic [31:0] trim_cnt;
        logic [31:0] alarm_cnt;
        logic [31:0] od_cnt;
        logic [5:0] diag;
        logic cancelled;
        logic [2:0] code;
        logic [4:0] dbit;
        logic [31:0] unit_cnt;
        logic [7:0] trim_gain;
        logic [7:0] init_gain;
        logic waitreq;
        logic [31:0] rdata;
        logic pull;
        logic rls;
        logic clutch;
        logic alarm;
        logic od;
        logic pedal_ind;
        logic diag_out;
    } state_s;

    localparam state_s STATE_RST = '{
        mode: ST_OFF,
        waitreq: 1'b1,
        trim_gain: `TRIM_GAIN_RST,
        init_gain: `INIT_GAIN_RST,
        default: '0
    };

    state_s s_q;
    state_s s_d;

    // next set cause after cur, wrapping
    function automatic logic [2:0] next_code(input logic [2:0] cur,
                                             input logic [5:0] m);
        logic [2:0] j;
        logic found;
        next_code = cur;
        found = 1'b0;
        j = cur;
        for (int i = 0; i < 6; i++) begin
            j = (j == 3'd5) ? 3'd0 : j + 3'd1;
            if (m[j] && !found) begin
                next_code = j;
                found = 1'b1;
            end
        end
    endfunction

    // long mark for the tens digit, one short mark per unit, then a gap
    function automatic logic [`DIAG_PAT_W-1:0] code_pat(input logic [2:0] k);
        logic [`DIAG_PAT_W-1:0] p;
        p = '0;
        p[19:16] = 4'b1110;
        for (int i = 0; i < 6; i++) begin
            if (3'(i) <= k) begin
                p[15-2*i] = 1'b1;
            end
        end
        code_pat = p;
    endfunction

    logic [7:0] sw;
    logic [7:0] rise;
    logic set_fall;
    logic brake;
    logic cancel_in;
    logic held;
    logic pulse_rise;
    logic [5:0] cause;
    logic [7:0] clamped;
    logic [7:0] dev_mag;
    logic [31:0] pw;
    logic show;
    logic [4:0] pat_len;
    logic [`DIAG_PAT_W-1:0] pat;

    always_comb begin
        s_d = s_q;
        sw = s_q.sw;
        rise = s_q.sw & ~s_q.sw_prev;
        set_fall = s_q.sw_prev[1] & ~s_q.sw[1];
        cause = '0;
        clamped = '0;
        dev_mag = '0;
        pw = '0;
        show = 1'b0;
        pat_len = '0;
        pat = '0;

        s_d.sync1 = {speed_pulse_i, pedal_i, inhibit_i, load_ok_i,
                     brake_nc_i, stop_sw_i, resume_sw_i, set_sw_i,
                     main_sw_i};
        s_d.sync2 = s_q.sync1;
        s_d.sw_prev = s_q.sw;

        for (int i = 0; i < 8; i++) begin
            if (s_q.sync2[i] != s_q.sw[i]) begin
                if (s_q.db_cnt[i] >= 32'(DEBOUNCE_CYC - 1)) begin
                    s_d.sw[i] = s_q.sync2[i];
                    s_d.db_cnt[i] = '0;
                end else begin
                    s_d.db_cnt[i] = s_q.db_cnt[i] + 32'd1;
                end
            end else begin
                s_d.db_cnt[i] = '0;
            end
        end

        pulse_rise = s_q.sync2[8] & ~s_q.pulse_prev;
        s_d.pulse_prev = s_q.sync2[8];
        if (pulse_rise) begin
            s_d.idle_cnt = '0;
            if (s_q.pcount != 8'hff) begin
                s_d.pcount = s_q.pcount + 8'd1;
            end
        end else if (s_q.idle_cnt != 32'hffff_ffff) begin
            s_d.idle_cnt = s_q.idle_cnt + 32'd1;
        end
        if (s_q.gate_cnt >= 32'(GATE_CYC - 1)) begin
            s_d.gate_cnt = '0;
            s_d.speed = s_d.pcount;
            s_d.pcount = '0;
        end else begin
            s_d.gate_cnt = s_q.gate_cnt + 32'd1;
        end

        clamped = (s_q.speed >= `SPEED_HIGH) ? `SPEED_HIGH : s_q.speed;

        brake = sw[3] | ~sw[4];
        cancel_in = brake | sw[6];
        held = (s_q.mode == ST_HOLD) || (s_q.mode == ST_DECELERATE) ||
               (s_q.mode == ST_ACCELERATE);

        cause[`CAUSE_LOAD] = ~sw[5];
        cause[`CAUSE_SENSOR] = s_q.idle_cnt > 32'(NOPULSE_CYC);
        cause[`CAUSE_LOW] = s_q.speed <= `SPEED_LOW;
        cause[`CAUSE_DROP] = {1'b0, s_q.speed} + {1'b0, `SPEED_DROP} <=
                             {1'b0, s_q.target};
        cause[`CAUSE_SWITCH] = cancel_in & (sw[1] | sw[2]);
        cause[`CAUSE_CANCEL] = cancel_in;

        if (s_q.pulse_cnt != '0) begin
            s_d.pulse_cnt = s_q.pulse_cnt - 32'd1;
        end
        if (s_q.od_cnt != '0) begin
            s_d.od_cnt = s_q.od_cnt - 32'd1;
        end
        if (s_q.alarm_cnt != '0) begin
            s_d.alarm_cnt = s_q.alarm_cnt - 32'd1;
        end

        if (!sw[0]) begin
            s_d.mode = ST_OFF;
            s_d.tvalid = 1'b0;
            s_d.diag = '0;
            s_d.cancelled = 1'b0;
            s_d.pulse_cnt = '0;
            s_d.od_cnt = '0;
            s_d.alarm_cnt = '0;
        end else begin
            if (rise[1] | rise[2]) begin
                s_d.alarm_cnt = 32'(ALARM_CYC);
            end
            if (held && cause != '0) begin
                s_d.diag = s_q.diag | cause;
                s_d.cancelled = 1'b1;
                s_d.mode = ST_IDLE;
                s_d.pulse_cnt = '0;
            end else begin
                case (s_q.mode)
                    ST_OFF: begin
                        s_d.mode = ST_IDLE;
                    end
                    ST_IDLE: begin
                        if (set_fall && s_q.speed > `SPEED_LOW) begin
                            s_d.target = clamped;
                            s_d.tvalid = 1'b1;
                            s_d.mode = ST_HOLD;
                            s_d.dir_pull = 1'b1;
                            s_d.pulse_cnt = (32'(s_q.speed) *
                                32'(s_q.init_gain)) << `PW_SHIFT;
                        end else if (rise[2] && s_q.tvalid &&
                                     s_q.speed >= `SPEED_LOW &&
                                     !sw[1] && !cancel_in) begin
                            s_d.mode = ST_HOLD;
                            s_d.od_cnt = 32'(OD_CYC);
                            s_d.dir_pull = 1'b1;
                            s_d.pulse_cnt = (32'(s_q.target) *
                                32'(s_q.init_gain)) << `PW_SHIFT;
                        end
                    end
                    ST_HOLD: begin
                        if (rise[1] || (sw[1] && sw[2])) begin
                            s_d.mode = ST_DECELERATE;
                            s_d.pulse_cnt = '0;
                        end else if (rise[2]) begin
                            s_d.mode = ST_ACCELERATE;
                            s_d.pulse_cnt = '0;
                        end
                        if (s_q.speed < s_q.target) begin
                            s_d.od_cnt = 32'(OD_CYC);
                        end
                    end
                    ST_DECELERATE: begin
                        if (!sw[1] && !sw[2]) begin
                            s_d.target = clamped;
                            s_d.mode = ST_HOLD;
                        end
                    end
                    ST_ACCELERATE: begin
                        s_d.od_cnt = 32'(OD_CYC);
                        if (sw[1]) begin
                            s_d.mode = ST_DECELERATE;
                        end else if (!sw[2]) begin
                            s_d.target = clamped;
                            s_d.mode = ST_HOLD;
                        end
                    end
                    default: begin
                        s_d.mode = ST_OFF;
                    end
                endcase
            end
        end

        // trim pulses, smaller at wider throttle
        if (s_d.mode == ST_HOLD && s_q.mode == ST_HOLD) begin
            if (s_q.trim_cnt >= 32'(TRIM_CYC - 1)) begin
                s_d.trim_cnt = '0;
                if (s_q.pulse_cnt == '0 && s_q.speed != s_q.target) begin
                    s_d.dir_pull = s_q.speed < s_q.target;
                    dev_mag = s_d.dir_pull ? s_q.target - s_q.speed :
                                             s_q.speed - s_q.target;
                    pw = (32'(dev_mag) * 32'(s_q.trim_gain)) << `PW_SHIFT;
                    s_d.pulse_cnt = pw >> throttle_i[7:6];
                end
            end else begin
                s_d.trim_cnt = s_q.trim_cnt + 32'd1;
            end
        end else begin
            s_d.trim_cnt = '0;
        end

        show = sw[0] && s_q.cancelled && s_q.diag != '0 &&
               s_q.speed < `SPEED_DIAG;
        pat_len = 5'd10 + {s_q.code, 1'b0};
        if (!show) begin
            s_d.code = next_code(3'd5, s_q.diag);
            s_d.dbit = '0;
            s_d.unit_cnt = '0;
            s_d.diag_out = 1'b0;
        end else begin
            if (s_q.unit_cnt >= 32'(DIAG_UNIT_CYC - 1)) begin
                s_d.unit_cnt = '0;
                if (s_q.dbit >= pat_len - 5'd1) begin
                    s_d.dbit = '0;
                    s_d.code = next_code(s_q.code, s_q.diag);
                end else begin
                    s_d.dbit = s_q.dbit + 5'd1;
                end
            end else begin
                s_d.unit_cnt = s_q.unit_cnt + 32'd1;
            end
            pat = code_pat(s_d.code);
            s_d.diag_out = pat[5'd19 - s_d.dbit];
        end

        // bus slave: one wait cycle, then the access completes
        s_d.waitreq = 1'b1;
        if ((read_i || write_i) && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata = '0;
            case (address_i)
                `REG_STATUS: begin
                    s_d.rdata = {11'h000, s_q.clutch, s_q.tvalid,
                                 s_q.mode, s_q.target, s_q.speed};
                end
                `REG_DIAG: begin
                    s_d.rdata = {23'h00_0000, show, 2'b00, s_q.diag};
                end
                `REG_GAIN: begin
                    s_d.rdata = {16'h0000, s_q.init_gain, s_q.trim_gain};
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end
        if (write_i && !s_q.waitreq && address_i == `REG_GAIN) begin
            if (byteenable_i[0]) begin
                s_d.trim_gain = writedata_i[7:0];
            end
            if (byteenable_i[1]) begin
                s_d.init_gain = writedata_i[15:8];
            end
        end

        s_d.clutch = (s_d.mode == ST_HOLD) || (s_d.mode == ST_DECELERATE) ||
                     (s_d.mode == ST_ACCELERATE);
        s_d.pull = (s_d.mode == ST_ACCELERATE) ||
                   (s_d.clutch && s_d.pulse_cnt != '0 && s_d.dir_pull);
        s_d.rls = (s_d.mode == ST_DECELERATE) ||
                  (s_d.clutch && s_d.pulse_cnt != '0 && !s_d.dir_pull);
        s_d.alarm = s_d.alarm_cnt != '0;
        s_d.od = s_d.od_cnt != '0;
        s_d.pedal_ind = sw[7] & ~s_d.clutch;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign readdata_o = s_q.rdata;
    assign waitrequest_o = s_q.waitreq;
    assign motor_pull_o = s_q.pull;
    assign motor_release_o = s_q.rls;
    assign clutch_o = s_q.clutch;
    assign alarm_o = s_q.alarm;
    assign od_cancel_o = s_q.od;
    assign pedal_ind_o = s_q.pedal_ind;
    assign diag_o = s_q.diag_out;

endmodule // cruise_speed_controller

// [cruise_checker_sva.sv]
// checker: cancel, alarm and output relations
// assumes the design's shortened counts
`timescale 1ns/1ps
module cruise_checker #(
    parameter int unsigned NOPULSE_CYC = 200,
    parameter int unsigned ALARM_CYC = 50
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic main_sw_i,
    input wire logic stop_sw_i,
    input wire logic brake_nc_i,
    input wire logic load_ok_i,
    input wire logic inhibit_i,
    input wire logic speed_pulse_i,
    input wire logic motor_pull_o,
    input wire logic motor_release_o,
    input wire logic clutch_o,
    input wire logic alarm_o,
    input wire logic pedal_ind_o,
    input wire logic diag_o
);
    int unsigned off_q;
    int unsigned quiet_q;
    int unsigned alarm_len_q;
    logic pulse_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            off_q <= 0;
            quiet_q <= 0;
            alarm_len_q <= 0;
            pulse_q <= 1'b0;
        end else begin
            off_q <= main_sw_i ? 0 : (off_q < 32 ? off_q + 1 : off_q);
            pulse_q <= speed_pulse_i;
            quiet_q <= (speed_pulse_i && !pulse_q) ? 0 :
                (quiet_q < NOPULSE_CYC + 64 ? quiet_q + 1 : quiet_q);
            alarm_len_q <= alarm_o ? alarm_len_q + 1 : 0;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // cancel level held past the filter
    sequence s_cancel(x);
        clutch_o && x ##1 x [*8];
    endsequence

    AST_MAIN_OFF: assert property (off_q >= 16 |-> !clutch_o && !alarm_o
        && !motor_pull_o && !motor_release_o)
        else $error("active while off");
    AST_DIAG_MAIN: assert property (off_q >= 16 |-> !diag_o)
        else $error("blink while off");
    AST_STOP_CANCEL: assert property (s_cancel(stop_sw_i) |-> ##[0:12] !clutch_o)
        else $error("stop lamp kept");
    AST_INHIBIT_CANCEL: assert property (s_cancel(inhibit_i) |-> ##[0:12] !clutch_o)
        else $error("inhibit kept");
    AST_BRAKE_CONTACT: assert property (s_cancel(!brake_nc_i) |-> ##[0:12] !clutch_o)
        else $error("brake kept");
    AST_LOAD_OPEN: assert property (s_cancel(!load_ok_i) |-> ##[0:12] !clutch_o)
        else $error("load open kept");
    AST_SENSOR_QUIET: assert property (quiet_q > NOPULSE_CYC + 16 |-> !clutch_o)
        else $error("sensor silent kept");
    AST_ALARM_LEN: assert property ($fell(alarm_o) |-> alarm_len_q == ALARM_CYC)
        else $error("alarm length");
    AST_PEDAL_OFF: assert property (clutch_o && $past(clutch_o) |-> !pedal_ind_o)
        else $error("pedal on");
    AST_MOTOR_EXCL: assert property (!(motor_pull_o && motor_release_o))
        else $error("motor both ways");
    AST_RELEASE_HELD: assert property (motor_release_o |-> clutch_o)
        else $error("release unheld");
endmodule // cruise_checker

bind cruise_speed_controller cruise_checker #(
    .NOPULSE_CYC(NOPULSE_CYC),
    .ALARM_CYC(ALARM_CYC)
) i_cruise_checker (.clk_i(clk_i), .rstn_i(rstn_i), .main_sw_i(main_sw_i),
    .stop_sw_i(stop_sw_i), .brake_nc_i(brake_nc_i), .load_ok_i(load_ok_i),
    .inhibit_i(inhibit_i), .speed_pulse_i(speed_pulse_i),
    .motor_pull_o(motor_pull_o), .motor_release_o(motor_release_o),
    .clutch_o(clutch_o), .alarm_o(alarm_o), .pedal_ind_o(pedal_ind_o),
    .diag_o(diag_o));

// [cruise_road_model.sv]
// road model: sensor pulses and throttle position
// assumes period_i cycles per pulse, 0 when stopped
`timescale 1ns/1ps
module cruise_road_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] period_i,
    input wire logic motor_pull_i,
    input wire logic motor_release_i,
    output logic speed_pulse_o,
    output logic [7:0] throttle_o
);
    logic [7:0] phase_q;
    logic [15:0] pos_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_q <= 8'h00;
            pos_q <= 16'h0000;
        end else begin
            phase_q <= (phase_q + 8'h01 >= period_i) ? 8'h00 : phase_q + 8'h01;
            if (motor_pull_i && pos_q != 16'hffff) begin
                pos_q <= pos_q + 16'h0001;
            end else if (motor_release_i && pos_q != 16'h0000) begin
                pos_q <= pos_q - 16'h0001;
            end
        end
    end

    // half period high, line idles low
    assign speed_pulse_o = (period_i != 8'h00) && (phase_q < {1'b0, period_i[7:1]});
    assign throttle_o = pos_q[15:8];
endmodule // cruise_road_model

// [tb_top.sv]
// bench: switch and bus stimulus, output checks
// assumes shortened counts; a gate is 400 cycles
`timescale 1ns/1ps
module tb_top import cruise_pkg::*;;
    logic clk_i = 1'b0;
    logic rstn_i, main_sw_i, set_sw_i, resume_sw_i, stop_sw_i, brake_nc_i;
    logic load_ok_i, inhibit_i, pedal_i, speed_pulse_i, read_i, write_i;
    logic [7:0] throttle_i, period;
    logic [3:0] address_i, byteenable_i;
    logic [31:0] writedata_i, readdata_o;
    logic waitrequest_o, motor_pull_o, motor_release_o, clutch_o;
    logic alarm_o, od_cancel_o, pedal_ind_o, diag_o;
    int bad_count = 0;
    int total_checks = 0;

    always #2.5 clk_i = ~clk_i;

    cruise_speed_controller #(.NOPULSE_CYC(200), .ALARM_CYC(50), .OD_CYC(100),
        .DEBOUNCE_CYC(4), .GATE_CYC(400), .DIAG_UNIT_CYC(8), .TRIM_CYC(40)
    ) i_cruise_speed_controller (.clk_i(clk_i), .rstn_i(rstn_i),
        .main_sw_i(main_sw_i), .set_sw_i(set_sw_i), .resume_sw_i(resume_sw_i),
        .stop_sw_i(stop_sw_i), .brake_nc_i(brake_nc_i), .load_ok_i(load_ok_i),
        .inhibit_i(inhibit_i), .pedal_i(pedal_i), .speed_pulse_i(speed_pulse_i),
        .throttle_i(throttle_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .motor_pull_o(motor_pull_o),
        .motor_release_o(motor_release_o), .clutch_o(clutch_o),
        .alarm_o(alarm_o), .od_cancel_o(od_cancel_o),
        .pedal_ind_o(pedal_ind_o), .diag_o(diag_o));

    cruise_road_model i_cruise_road_model (.clk_i(clk_i), .rstn_i(rstn_i),
        .period_i(period), .motor_pull_i(motor_pull_o),
        .motor_release_i(motor_release_o), .speed_pulse_o(speed_pulse_i),
        .throttle_o(throttle_i));

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp_word(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic cmp_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // held until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= wd;
        write_i <= wr;
        read_i <= !wr;
        do begin
            @(posedge clk_i);
        end while (waitrequest_o !== 1'b0);
        rd = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rchk(input string nm, input logic [3:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        cmp_word(nm, e, r & m);
    endtask

    task automatic wt;
        repeat (40) @(posedge clk_i);
    endtask

    task automatic sw(input logic s, input logic r);
        set_sw_i <= s;
        resume_sw_i <= r;
        wt();
    endtask

    // three gates
    task automatic spd(input logic [7:0] p);
        period <= p;
        repeat (1200) @(posedge clk_i);
    endtask

    task automatic s_main_off;
        rchk("gain reset", 4'h8, 32'hffff_ffff, 32'h0000_1004);
        wr(4'hc, 32'hffff_ffff);
        rchk("unmapped", 4'hc, 32'hffff_ffff, 32'h0000_0000);
        byteenable_i <= 4'h2;
        wr(4'h8, 32'h0000_0100);
        byteenable_i <= 4'hf;
        rchk("gain", 4'h8, 32'hffff_ffff, 32'h0000_0104);
        spd(8'h05);
        sw(1'b1, 1'b0);
        cmp_bit("alarm off", 1'b0, alarm_o);
        sw(1'b0, 1'b0);
        cmp_bit("clutch off", 1'b0, clutch_o);
        rchk("mode off", 4'h0, 32'h0007_0000, 32'h0000_0000);
    endtask

    task automatic s_engage;
        main_sw_i <= 1'b1;
        pedal_i <= 1'b1;
        sw(1'b1, 1'b0);
        cmp_bit("alarm", 1'b1, alarm_o);
        sw(1'b0, 1'b0);
        cmp_bit("clutch set", 1'b1, clutch_o);
        cmp_bit("initial pull", 1'b1, motor_pull_o);
        cmp_bit("pedal ind", 1'b0, pedal_ind_o);
        rchk("target", 4'h0, 32'h0000_ff00, 32'h0000_5000);
        brake_nc_i <= 1'b0;
        wt();
        cmp_bit("brake contact", 1'b0, clutch_o);
        cmp_bit("pedal copy", 1'b1, pedal_ind_o);
        rchk("cause brake", 4'h4, 32'h0000_0020, 32'h0000_0020);
        brake_nc_i <= 1'b1;
        sw(1'b0, 1'b1);
        cmp_bit("clutch resume", 1'b1, clutch_o);
        sw(1'b0, 1'b0);
        stop_sw_i <= 1'b1;
        wt();
        cmp_bit("stop lamp", 1'b0, clutch_o);
        stop_sw_i <= 1'b0;
        wr(4'h8, 32'h0000_0000);
    endtask

    task automatic s_limits;
        spd(8'h02);
        sw(1'b1, 1'b0);
        sw(1'b0, 1'b0);
        rchk("target clamp", 4'h0, 32'h0000_ff00, 32'h0000_9100);
        sw(1'b0, 1'b1);
        cmp_bit("pull", 1'b1, motor_pull_o);
        cmp_bit("od cancel", 1'b1, od_cancel_o);
        rchk("mode acc", 4'h0, 32'h0007_0000, 32'h0004_0000);
        sw(1'b0, 1'b0);
        rchk("acc clamp", 4'h0, 32'h0000_ff00, 32'h0000_9100);
        sw(1'b1, 1'b1);
        cmp_bit("both release", 1'b1, motor_release_o);
        rchk("mode dec", 4'h0, 32'h0007_0000, 32'h0003_0000);
        sw(1'b0, 1'b0);
        load_ok_i <= 1'b0;
        wt();
        cmp_bit("load open", 1'b0, clutch_o);
        rchk("cause load", 4'h4, 32'h0000_0001, 32'h0000_0001);
        load_ok_i <= 1'b1;
        sw(1'b0, 1'b1);
        sw(1'b0, 1'b0);
        inhibit_i <= 1'b1;
        sw(1'b0, 1'b1);
        cmp_bit("cancel cmd", 1'b0, clutch_o);
        rchk("cause both", 4'h4, 32'h0000_0010, 32'h0000_0010);
        inhibit_i <= 1'b0;
        sw(1'b0, 1'b0);
    endtask

    task automatic s_low;
        spd(8'h08);
        sw(1'b1, 1'b0);
        sw(1'b0, 1'b0);
        spd(8'h0a);
        cmp_bit("low limit", 1'b0, clutch_o);
        rchk("cause low", 4'h4, 32'h0000_0004, 32'h0000_0004);
        spd(8'h08);
        sw(1'b0, 1'b1);
        cmp_bit("resume", 1'b1, clutch_o);
        cmp_bit("od resume", 1'b1, od_cancel_o);
        rchk("old target", 4'h0, 32'h0000_ff00, 32'h0000_3200);
        sw(1'b0, 1'b0);
        sw(1'b1, 1'b0);
        cmp_bit("decelerate_command", 1'b1, motor_release_o);
        spd(8'h05);
        sw(1'b0, 1'b0);
        rchk("decelerate_command target", 4'h0, 32'h0000_ff00, 32'h0000_5000);
        spd(8'h08);
        cmp_bit("drop", 1'b0, clutch_o);
        rchk("cause drop", 4'h4, 32'h0000_0008, 32'h0000_0008);
    endtask

    task automatic s_diag;
        int k;
        spd(8'h19);
        rchk("display on", 4'h4, 32'h0000_0100, 32'h0000_0100);
        k = 0;
        repeat (400) begin
            @(posedge clk_i);
            if (diag_o === 1'b1) k++;
        end
        cmp_bit("blink", 1'b1, k > 0);
        spd(8'h10);
        rchk("display off", 4'h4, 32'h0000_0100, 32'h0000_0000);
        main_sw_i <= 1'b0;
        wt();
        rchk("codes lost", 4'h4, 32'hffff_ffff, 32'h0000_0000);
        rchk("mode off", 4'h0, 32'h0007_0000, 32'h0000_0000);
        cmp_bit("diag idle", 1'b0, diag_o);
    endtask

    initial begin
        {main_sw_i, set_sw_i, resume_sw_i, stop_sw_i, inhibit_i} = 5'h00;
        {brake_nc_i, load_ok_i, pedal_i, read_i, write_i} = 5'h18;
        rstn_i = 1'b0;
        period = 8'h00;
        address_i = 4'h0;
        byteenable_i = 4'hf;
        writedata_i = 32'h0000_0000;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        s_main_off();
        s_engage();
        s_limits();
        s_low();
        s_diag();
        results();
    end

    // about six times the run
    initial begin
        #400000;
        bad_count++;
        results();
    end
endmodule // tb_top
